// *** rcs_map.svh ***
// Purpose: Constants for the reset cause and release sequencer
// Assumes: 10 MHz system clock, byte addressed Avalon-MM words
// Notes: Offsets, field positions, reset values and timing counts
// ============================================================
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH
// ============================================================
// Register offsets (byte addresses)
`define RCS_OFS_CAUSE 4'h0
`define RCS_OFS_OSC 4'h4
`define RCS_OFS_CTRL 4'h8
`define RCS_OFS_STAT 4'hc
// ============================================================
// Cause flag bit positions
`define RCS_B_POR 0
`define RCS_B_BOR 1
`define RCS_B_IDLE 2
`define RCS_B_SLEEP 3
`define RCS_B_WATCHDOG_TIMEOUT_FLAG 4
`define RCS_B_SWR 6
`define RCS_B_EXTERNAL_PIN_RESET_FLAG 7
`define RCS_B_BADOP 14
`define RCS_B_TRAP 15
`define RCS_CAUSE_MASK 16'hc0df
`define RCS_CAUSE_RESET 16'h0003
// Oscillator control: current field at 14:12
`define RCS_OSC_LSB 12
// Control register bits
`define RCS_C_SWEN 0
`define RCS_C_REGEN 1
`define RCS_C_MONEN 2
`define RCS_C_MONLONG 3
`define RCS_CTRL_RESET 4'h7
// ============================================================
// Times, in ns, and cycle counts at 100 ns per cycle
`define RCS_CLK_NS 100
`define RCS_T_POR_NS 10000
`define RCS_T_STARTUP_NS 20000
`define RCS_T_POWER_UP_TIMER_NS 64000000
`define RCS_T_RST_NS 20000
`define RCS_T_LOCK_NS 20000
`define RCS_T_MON_S_NS 100000
`define RCS_T_MON_L_NS 500000
`define RCS_OST_COUNT 1024
`define RCS_CYC(t) (((t) + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`endif

// *** rcs_pkg.sv ***
// Purpose: Types for the reset cause and release sequencer
// Assumes: Used with rcs_map.svh
// Notes: Types only
package rcs_pkg;
   typedef enum logic [2:0] {
      RCS_OSC_FRC, RCS_OSC_FRCPLL, RCS_OSC_PRI, RCS_OSC_PRIPLL,
      RCS_OSC_SEC, RCS_OSC_LPRC, RCS_OSC_EC, RCS_OSC_ECPLL
   } rcs_osc_e;
   typedef struct packed {
      logic por;
      logic bor;
      logic master_clear_pin;
      logic wdt;
      logic soft_reset_flag;
      logic trap;
      logic badop;
   } rcs_src_s;
   typedef struct packed {
      logic sleep;
      logic idle;
   } rcs_save_s;
endpackage : rcs_pkg

// *** rcs_sequencer.sv ***
// Purpose: Reset source combiner, cause flags, clock select and release timing
// Assumes: All inputs synchronous to clk_sys; time base is clk_sys
// Notes: Registers on Avalon-MM, one wait state on every access
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "rcs_map.svh"
module rcs_sequencer #(
   parameter int unsigned POWER_UP_TIMER_CYC = `RCS_CYC(`RCS_T_POWER_UP_TIMER_NS),
   parameter int unsigned MON_L_CYC = `RCS_CYC(`RCS_T_MON_L_NS),
   parameter int unsigned OST_CNT = `RCS_OST_COUNT
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire rcs_pkg::rcs_src_s reset_src,
   input wire rcs_pkg::rcs_save_s save_evt,
   input wire logic [2:0] config_oscillator_select,
   input wire logic osc_edge,
   input wire logic pll_locked,
   input wire logic clock_valid,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic master_system_reset,
   output logic clock_released,
   output logic fetch_enable,
   output logic monitor_active,
   output logic clock_fail_trap,
   output logic [2:0] system_clock_source
);
   import rcs_pkg::*;

   localparam int unsigned POR_CYC = `RCS_CYC(`RCS_T_POR_NS);
   localparam int unsigned SU_CYC = `RCS_CYC(`RCS_T_STARTUP_NS);
   localparam int unsigned RST_CYC = `RCS_CYC(`RCS_T_RST_NS);
   localparam int unsigned LOCK_CYC = `RCS_CYC(`RCS_T_LOCK_NS);
   localparam int unsigned MON_S_CYC = `RCS_CYC(`RCS_T_MON_S_NS);
   localparam int CW = 32;

   typedef enum logic [2:0] {
      RCS_RUN, RCS_PORD, RCS_SUD, RCS_RSTD
   } rcs_seq_e;

   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == RCS_OSC_FRCPLL) || (s == RCS_OSC_PRIPLL) || (s == RCS_OSC_ECPLL);
   endfunction : is_pll

   function automatic logic is_xtal(input logic [2:0] s);
      is_xtal = (s == RCS_OSC_PRI) || (s == RCS_OSC_PRIPLL) || (s == RCS_OSC_SEC);
   endfunction : is_xtal

   // ============================================================
   // Reset source decode
   logic pwr_rst;
   logic any_rst;
   assign pwr_rst = reset_src.por | reset_src.bor;
   assign any_rst = pwr_rst | reset_src.master_clear_pin | reset_src.wdt | reset_src.soft_reset_flag
      | reset_src.trap | reset_src.badop;

   logic [15:0] cause_r;
   logic [3:0] ctrl_r;
   logic [2:0] cur_osc_r;
   rcs_seq_e seq_r;
   logic [CW-1:0] dly_r;
   logic [CW-1:0] clk_cnt_r;
   logic [CW-1:0] mon_cnt_r;
   logic ost_done_r;
   logic lock_done_r;
   logic mon_wait_r;
   logic ack_r;

   // ============================================================
   // Bus slave: one wait state, then the answer
   logic bus_req;
   logic wr_go;
   logic rd_go;
   assign bus_req = (avs_read | avs_write) & ~ack_r;
   assign wr_go = avs_write & ack_r;
   assign rd_go = avs_read & ack_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~bus_req;
      end
   end

   logic [15:0] wmask;
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (bus_req && avs_read) begin
         case (avs_address)
            `RCS_OFS_CAUSE: avs_readdata <= {16'h0, cause_r};
            `RCS_OFS_OSC: avs_readdata <= {16'h0, 1'b0, cur_osc_r, 12'h0};
            `RCS_OFS_CTRL: avs_readdata <= {28'h0, ctrl_r};
            `RCS_OFS_STAT: avs_readdata <= {26'h0, clock_fail_trap, monitor_active,
               fetch_enable, clock_released, master_system_reset, 1'b0};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_r <= `RCS_CTRL_RESET;
      end else if (wr_go && avs_address == `RCS_OFS_CTRL && avs_byteenable[0]) begin
         ctrl_r <= avs_writedata[3:0];
      end
   end

   // ============================================================
   // Cause flags: hardware set wins over software clear
   logic [15:0] hw_set;
   logic [15:0] hw_clr;
   logic [15:0] sw_val;
   always_comb begin
      hw_set = 16'h0;
      hw_set[`RCS_B_POR] = reset_src.por;
      hw_set[`RCS_B_BOR] = pwr_rst;
      hw_set[`RCS_B_EXTERNAL_PIN_RESET_FLAG] = reset_src.master_clear_pin;
      hw_set[`RCS_B_SWR] = reset_src.soft_reset_flag;
      hw_set[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = reset_src.wdt;
      hw_set[`RCS_B_TRAP] = reset_src.trap;
      hw_set[`RCS_B_BADOP] = reset_src.badop;
      hw_set[`RCS_B_SLEEP] = save_evt.sleep;
      hw_set[`RCS_B_IDLE] = save_evt.idle;
      hw_clr = 16'h0;
      if (reset_src.por) begin
         hw_clr = ~16'h0;
      end else if (reset_src.bor) begin
         hw_clr = `RCS_CAUSE_MASK;
         hw_clr[`RCS_B_EXTERNAL_PIN_RESET_FLAG] = 1'b0;
         // Power-on flag survives a brown-out; only software clears it
         hw_clr[`RCS_B_POR] = 1'b0;
      end
      hw_clr[`RCS_B_WATCHDOG_TIMEOUT_FLAG] = hw_clr[`RCS_B_WATCHDOG_TIMEOUT_FLAG] | save_evt.sleep | save_evt.idle;
      sw_val = (cause_r & ~wmask) | (avs_writedata[15:0] & wmask);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cause_r <= `RCS_CAUSE_RESET;
      end else if (wr_go && avs_address == `RCS_OFS_CAUSE) begin
         // Software write never starts a reset
         cause_r <= ((sw_val & ~hw_clr) | hw_set) & `RCS_CAUSE_MASK;
      end else begin
         cause_r <= ((cause_r & ~hw_clr) | hw_set) & `RCS_CAUSE_MASK;
      end
   end

   // ============================================================
   // Clock source selection at reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         // Reset runs the power-on sequence, so the configured source applies
         cur_osc_r <= config_oscillator_select;
      end else if (!ctrl_r[`RCS_C_SWEN] && any_rst) begin
         cur_osc_r <= config_oscillator_select;
      end else if (pwr_rst) begin
         cur_osc_r <= config_oscillator_select;
      end else if (monitor_active && !clock_valid) begin
         cur_osc_r <= RCS_OSC_FRC;
      end else if (wr_go && avs_address == `RCS_OFS_OSC && avs_byteenable[1]) begin
         cur_osc_r <= avs_writedata[`RCS_OSC_LSB +: 3];
      end
   end
   assign system_clock_source = cur_osc_r;

   // ============================================================
   // Reset release sequence
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         seq_r <= RCS_PORD;
         dly_r <= CW'(POR_CYC);
      end else if (reset_src.por) begin
         seq_r <= RCS_PORD;
         dly_r <= CW'(POR_CYC);
      end else if (any_rst) begin
         seq_r <= RCS_RSTD;
         dly_r <= CW'(RST_CYC);
      end else if (save_evt.sleep && ctrl_r[`RCS_C_REGEN]) begin
         seq_r <= RCS_SUD;
         dly_r <= CW'(SU_CYC);
      end else begin
         case (seq_r)
            RCS_RUN: begin
               dly_r <= dly_r;
            end
            RCS_PORD, RCS_SUD, RCS_RSTD: begin
               if (dly_r > CW'(1)) begin
                  dly_r <= dly_r - CW'(1);
               end else if (seq_r == RCS_PORD) begin
                  seq_r <= RCS_SUD;
                  dly_r <= ctrl_r[`RCS_C_REGEN] ? CW'(SU_CYC) : CW'(POWER_UP_TIMER_CYC);
               end else if (seq_r == RCS_SUD) begin
                  seq_r <= RCS_RSTD;
                  dly_r <= CW'(RST_CYC);
               end else begin
                  seq_r <= RCS_RUN;
               end
            end
            default: begin
               seq_r <= RCS_PORD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         master_system_reset <= 1'b1;
      end else begin
         master_system_reset <= any_rst || (seq_r != RCS_RUN);
      end
   end

   // ============================================================
   // Oscillator start and PLL lock, in parallel with reset delays
   logic clk_ready;
   assign clk_ready = ost_done_r && lock_done_r;

   always_ff @(posedge clk_sys) begin
      if (rst || pwr_rst) begin
         ost_done_r <= 1'b0;
         lock_done_r <= 1'b0;
         clk_cnt_r <= '0;
      end else if (!ost_done_r) begin
         if (!is_xtal(cur_osc_r) || clk_cnt_r == CW'(OST_CNT)) begin
            ost_done_r <= 1'b1;
            clk_cnt_r <= '0;
         end else if (osc_edge) begin
            clk_cnt_r <= clk_cnt_r + CW'(1);
         end
      end else if (!lock_done_r) begin
         if (!is_pll(cur_osc_r) || (pll_locked && clk_cnt_r >= CW'(LOCK_CYC))) begin
            lock_done_r <= 1'b1;
         end else begin
            clk_cnt_r <= clk_cnt_r + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clock_released <= 1'b0;
         fetch_enable <= 1'b0;
      end else begin
         clock_released <= clk_ready;
         fetch_enable <= clk_ready && (seq_r == RCS_RUN) && !any_rst;
      end
   end

   // ============================================================
   // Fail-safe monitor start and trap
   always_ff @(posedge clk_sys) begin
      // A regulated sleep wake holds reset again, so the monitor restarts too
      if (rst || any_rst || (save_evt.sleep && ctrl_r[`RCS_C_REGEN])) begin
         mon_wait_r <= 1'b1;
         mon_cnt_r <= '0;
         monitor_active <= 1'b0;
      end else if (seq_r == RCS_RUN && ctrl_r[`RCS_C_MONEN] && !monitor_active) begin
         if (!(is_xtal(cur_osc_r) || is_pll(cur_osc_r)) || !mon_wait_r) begin
            monitor_active <= 1'b1;
         end else if (mon_cnt_r + CW'(1) >= (ctrl_r[`RCS_C_MONLONG] ?
               CW'(MON_L_CYC) : CW'(MON_S_CYC))) begin
            mon_wait_r <= 1'b0;
         end else begin
            mon_cnt_r <= mon_cnt_r + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || any_rst) begin
         clock_fail_trap <= 1'b0;
      end else if (monitor_active && !clock_valid) begin
         clock_fail_trap <= 1'b1;
      end
   end
endmodule : rcs_sequencer
`default_nettype wire

// *** rcs_chk.sv ***
// Purpose: Port-level assertions for rcs_sequencer
// Assumes: One clock domain, rst synchronous and active high
// Notes: Bound to every rcs_sequencer instance
`timescale 1ns/1ps
`default_nettype none
module rcs_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire rcs_pkg::rcs_src_s reset_src,
   input wire rcs_pkg::rcs_save_s save_evt,
   input wire logic clock_valid,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic master_system_reset,
   input wire logic clock_released,
   input wire logic fetch_enable,
   input wire logic monitor_active,
   input wire logic clock_fail_trap,
   input wire logic [2:0] system_clock_source
);
   import rcs_pkg::*;
   logic [9:0] hold_r;
   logic quiet;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ====
   // Helpers
   assign quiet = (reset_src == '0) && (save_evt == '0);
   // Saturates so a long power-up hold cannot wrap below the minimum
   always_ff @(posedge clk_sys) begin
      if (rst || !master_system_reset) hold_r <= 10'h0;
      else if (hold_r != 10'h3ff) hold_r <= hold_r + 10'h1;
   end
   // ====
   // Assertions
   AST_REQ_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus request not answered in one cycle");
   AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_FETCH_GATE: assert property (fetch_enable |-> clock_released && !master_system_reset)
      else $error("fetch enabled without released clock");
   AST_SRC_RESET: assert property (reset_src != '0 |-> ##[1:2] master_system_reset)
      else $error("reset source did not assert system reset");
   AST_HOLD_MIN: assert property ($fell(master_system_reset) |-> hold_r >= 10'hc8)
      else $error("system reset released too early");
   AST_QUIET: assert property (!master_system_reset && quiet && $past(quiet)
      |=> !master_system_reset)
      else $error("system reset without a source");
   AST_MON_AFTER: assert property (master_system_reset |-> !monitor_active)
      else $error("monitor active during reset");
   AST_TRAP_FRC: assert property ($rose(clock_fail_trap)
      |-> ##[0:1] system_clock_source == RCS_OSC_FRC)
      else $error("clock fail did not switch to internal source");
   AST_TRAP_CAUSE: assert property (clock_valid [*4] |-> !$rose(clock_fail_trap))
      else $error("clock fail trap with valid clock");
   COV_RELEASE: cover property ($fell(master_system_reset));
   COV_TRAP: cover property ($rose(clock_fail_trap));
   COV_WRITE: cover property (avs_write && !avs_waitrequest);
endmodule : rcs_chk
bind rcs_sequencer rcs_chk u_chk (.clk_sys, .rst, .reset_src, .save_evt, .clock_valid,
   .avs_read, .avs_write, .avs_waitrequest, .master_system_reset, .clock_released,
   .fetch_enable, .monitor_active, .clock_fail_trap, .system_clock_source);
`default_nettype wire

// *** rcs_clk_model.sv ***
// Purpose: Oscillator and PLL seen by the sequencer
// Assumes: Crystal ticks at half the system rate
// Notes: fail stops the crystal and drops lock and clock_valid
`timescale 1ns/1ps
`default_nettype none
module rcs_clk_model #(
   parameter int unsigned LOCK_CYC = 40
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic fail,
   output logic osc_edge,
   output logic pll_locked,
   output logic clock_valid
);
   logic [7:0] lock_r;
   // A dead crystal gives no periods at all
   always_ff @(posedge clk_sys) begin
      if (rst) osc_edge <= 1'b0;
      else osc_edge <= !osc_edge && !fail;
   end
   // Lock is slower than the crystal so both waits are exercised
   always_ff @(posedge clk_sys) begin
      if (rst) lock_r <= 8'h0;
      else if (lock_r != LOCK_CYC[7:0]) lock_r <= lock_r + 8'h1;
   end
   assign pll_locked = (lock_r == LOCK_CYC[7:0]) && !fail;
   assign clock_valid = !fail;
endmodule : rcs_clk_model
`default_nettype wire

// *** reset_cause_and_release_sequencer_test.sv ***
// Purpose: Self-checking bench for rcs_sequencer
// Assumes: Shortened power-up timer, monitor and start counts
// Notes: Expected cause flags kept in an integer model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
   $display("unexpected %s expected %0h seen %0h", n, e, g); bad_count++; end end
module reset_cause_and_release_sequencer_test;
   import rcs_pkg::*;
   logic clk_sys, rst, fail, osc_edge, pll_locked, clock_valid, msr;
   logic clock_released, fetch_enable, monitor_active, clock_fail_trap;
   rcs_src_s reset_src;
   rcs_save_s save_evt;
   logic [2:0] cfg_osc, clk_src;
   logic [3:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest;
   logic [31:0] avs_writedata, avs_readdata, q;
   int bad_count = 0, tests_run = 0, hold = 0, run_len = 0, cause;
   int flag_bit[5] = '{14, 15, 6, 4, 7};
   rcs_sequencer #(.POWER_UP_TIMER_CYC(50), .MON_L_CYC(60), .OST_CNT(16)) u_dut (.clk_sys, .rst,
      .reset_src, .save_evt, .config_oscillator_select(cfg_osc), .osc_edge, .pll_locked,
      .clock_valid, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .master_system_reset(msr),
      .clock_released, .fetch_enable, .monitor_active, .clock_fail_trap,
      .system_clock_source(clk_src));
   rcs_clk_model u_osc (.clk_sys, .rst, .fail, .osc_edge, .pll_locked, .clock_valid);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // Length of the last system reset pulse, reset cycles included;
   // counted on the falling edge so it is settled before the checks read it
   always @(negedge clk_sys) begin
      if (msr === 1'b1) run_len++;
      else if (run_len != 0) begin
         hold = run_len;
         run_len = 0;
      end
   end
   // ====
   // Tasks
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   task automatic wait_on(input int w);
      int n;
      for (n = 0; n < 3000; n++) begin
         if ((w == 0 ? fetch_enable : w == 1 ? monitor_active : clock_fail_trap) === 1'b1) break;
         @(posedge clk_sys);
      end
      if (n == 3000) begin
         bad_count++;
         print_verdict;
      end
   endtask : wait_on
   // Request held until waitrequest is seen low; an idle edge follows
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         bad_count++;
         print_verdict;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   // One-cycle pulse: 0 idle, 1 sleep, 2..8 bad opcode up to power-on
   task automatic kick(input int i);
      {reset_src, save_evt} <= 9'h1 << i;
      @(posedge clk_sys);
      {reset_src, save_evt} <= '0;
      repeat (3) @(posedge clk_sys);
      wait_on(0);
   endtask : kick
   // ====
   // Main sequence
   initial begin
      void'($urandom(32'hef8fc0d6));
      rst = 1'b1;
      fail = 1'b0;
      {reset_src, save_evt} = '0;
      cfg_osc = 3'h3;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      wait_on(0);
      `CHK("por hold", 1'b1, hold inside {[500:510]})
      `CHK("por source", 3'h3, clk_src)
      bus(0, 4'h0, 0); `CHK("cause", 16'h0003, q[15:0])
      bus(0, 4'h8, 0); `CHK("ctrl", 32'h7, q)
      bus(0, 4'hc, 0); `CHK("status", 32'hc, q)
      bus(0, 4'h6, 0); `CHK("unmapped", 32'h0, q)
      cause = $urandom & 32'hc0df;
      bus(1, 4'h0, cause); `CHK("sw reset", 1'b0, msr)
      bus(0, 4'h0, 0); `CHK("sw cause", cause[15:0], q[15:0])
      cfg_osc <= 3'h4;
      for (int i = 2; i < 7; i++) begin
         kick(i);
         cause = cause | (1 << flag_bit[i - 2]);
         `CHK("hold", 1'b1, hold inside {[200:205]})
         bus(0, 4'h0, 0); `CHK("cause", cause[15:0], q[15:0])
      end
      `CHK("kept source", 3'h3, clk_src)
      for (int i = 0; i < 2; i++) begin
         bus(1, 4'h0, cause | 32'h10);
         kick(i);
         cause = (cause | (4 << i)) & ~32'h10;
         bus(0, 4'h0, 0); `CHK("save cause", cause[15:0], q[15:0])
      end
      kick(7);
      cause = (cause & 32'h81) | 32'h2;
      bus(0, 4'h0, 0); `CHK("bor cause", cause[15:0], q[15:0])
      `CHK("bor source", 3'h4, clk_src)
      bus(1, 4'h8, 32'hc);
      cfg_osc <= 3'h2;
      kick(6);
      `CHK("fixed source", 3'h2, clk_src)
      bus(0, 4'h4, 0); `CHK("osc field", 3'h2, q[14:12])
      kick(8);
      `CHK("por hold", 1'b1, hold inside {[350:355]})
      bus(0, 4'h0, 0); `CHK("por cause", 16'h0003, q[15:0])
      wait_on(1);
      fail <= 1'b1;
      wait_on(2);
      `CHK("fail source", 3'h0, clk_src)
      print_verdict;
   end
endmodule : reset_cause_and_release_sequencer_test
`default_nettype wire
